// [pkg/gpc_pkg.sv]
// Purpose: Shared constants for the GPIO port pin control block.
// Assumes: One port of 32 pins, four peripheral functions per pin.
// Notes: Write operation codes select plain, set, clear or toggle writes.
package gpc_pkg;
	localparam int NUM_PINS = 32;
	localparam int NUM_FUNCS = 4;
	localparam int SEL_BITS = 2;
	localparam int NUM_REGS = 7;
	// Register selector codes
	localparam logic [2:0] REG_OWNERSHIP = 3'h0;
	localparam logic [2:0] REG_DRIVE_EN = 3'h1;
	localparam logic [2:0] REG_OUT_LEVEL = 3'h2;
	localparam logic [2:0] REG_PULLUP_EN = 3'h3;
	localparam logic [2:0] REG_IRQ_EN = 3'h4;
	localparam logic [2:0] REG_FSEL0 = 3'h5;
	localparam logic [2:0] REG_FSEL1 = 3'h6;
	localparam logic [2:0] REG_PIN_LEVEL = 3'h7;
	// Write operation codes
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_SET = 2'h1;
	localparam logic [1:0] OP_CLEAR = 2'h2;
	localparam logic [1:0] OP_TOGGLE = 2'h3;
	// Reset values
	localparam logic [31:0] RST_OWNERSHIP = 32'hFFFFFFFF;
	localparam logic [31:0] RST_DRIVE_EN = 32'h00000000;
	localparam logic [31:0] RST_OUT_LEVEL = 32'h00000000;
	localparam logic [31:0] RST_PULLUP_EN = 32'h00000000;
	localparam logic [31:0] RST_IRQ_EN = 32'h00000000;
	localparam logic [31:0] RST_FSEL = 32'h00000000;
	localparam logic [31:0] RST_PIN_LEVEL = 32'h00000000;
	localparam logic [31:0] ALL_IMPL = 32'hFFFFFFFF;
endpackage : gpc_pkg

// [verilog/gpc_port.sv]
// Purpose: Per-pin control of a 32-pin general-purpose I/O port.
// Assumes: clk is the port bus clock; pins arrive asynchronously.
// Notes: Peripheral pin path is purely combinational, so it works with
// Notes: the clock stopped; registers simply hold while clk is stopped.
`timescale 1ns/1ps

// Summary of operation
// - Control registers form one port, one bit per pin, 32 pins.
// - Most registers accept set, clear and toggle writes besides plain.
// - Pin level register reports the real pin level, whoever drives it.
// - Pin level bit updates only when owned by port or irq enabled.
// - Peripheral-owned pins take output and enable from selected function.
// - Port-owned pin is driven only when its drive-enable bit is one.
// - Port-owned driven pin carries its output level register bit.
// - Function code bit k comes from the k-th function-select register.
// - Selected function reaches the pin only while ownership bit is zero.
// - Peripheral controls pull-up if supported, else pull-up enable bit.
// - Features a peripheral does not control stay with port registers.
// - Port-controlled pull-up on when pull-up enable bit is one, off when zero.
// - Peripheral pin path does not depend on the bus clock.
// - Logic freezes while its clock is stopped and resumes afterwards.
// - Bus clock runs out of reset; only clock manager may stop it.
// - Port keeps operating normally during processor debug halt.
// - Set sets, clear clears, toggle inverts ones; zeros leave bits.
// - Unimplemented bits ignore writes and read as zero.
module gpc_port #(
	parameter logic [31:0] OWN_RESET = gpc_pkg::RST_OWNERSHIP,
	parameter logic [31:0] DRIVE_RESET = gpc_pkg::RST_DRIVE_EN,
	parameter logic [31:0] FSEL0_RESET = gpc_pkg::RST_FSEL,
	parameter logic [31:0] FSEL1_RESET = gpc_pkg::RST_FSEL,
	parameter logic [31:0] IMPL_MASK = gpc_pkg::ALL_IMPL,
	parameter logic [31:0] PERIPH_PULL_MASK = 32'h00000000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [2:0] reg_sel,
	input wire logic [1:0] reg_op,
	input wire logic [31:0] reg_wdata,
	input wire logic [2:0] reg_rsel,
	output logic [31:0] reg_rdata,
	output logic [31:0] pin_level_reg,
	output logic [31:0] pin_irq_enable_reg,
	input wire logic [31:0] port_pin_n_in,
	output logic [31:0] port_pin_n_out,
	output logic [31:0] port_pin_n_oe,
	output logic [31:0] port_pin_n_pullup,
	input wire logic [127:0] periph_out,
	input wire logic [127:0] periph_oe,
	input wire logic [127:0] periph_pull_en,
	input wire logic [127:0] periph_pull_ctl,
	output logic [127:0] periph_in
);
	logic [31:0] regs_ff [gpc_pkg::NUM_REGS];
	logic [31:0] nxt_regs [gpc_pkg::NUM_REGS];
	logic [gpc_pkg::NUM_REGS-1:0] wr_hit;
	logic [31:0] sync1_ff;
	logic [31:0] sync2_ff;
	logic [31:0] nxt_sync1;
	logic [31:0] nxt_sync2;
	logic [31:0] pin_level_ff;
	logic [31:0] nxt_pin_level;
	logic [31:0] level_upd;
	logic [31:0] own;
	logic [31:0] drive_en;
	logic [31:0] out_level;
	logic [31:0] pullup_en;
	logic [31:0] irq_en;
	logic [31:0] fsel_bit0;
	logic [31:0] fsel_bit1;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	function automatic logic [31:0] rst_val(input int idx);
		logic [31:0] val;
		val = 32'h00000000;
		case (idx)
			0: val = OWN_RESET;
			1: val = DRIVE_RESET;
			2: val = gpc_pkg::RST_OUT_LEVEL;
			3: val = gpc_pkg::RST_PULLUP_EN;
			4: val = gpc_pkg::RST_IRQ_EN;
			5: val = FSEL0_RESET;
			6: val = FSEL1_RESET;
			default: val = 32'h00000000;
		endcase
		return val & IMPL_MASK;
	endfunction : rst_val

	// Plain, set, clear or toggle applied to one register word
	function automatic logic [31:0] apply_op(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [1:0] op
	);
		logic [31:0] res;
		res = old;
		unique case (op)
			gpc_pkg::OP_WRITE: res = data;
			gpc_pkg::OP_SET: res = old | data;
			gpc_pkg::OP_CLEAR: res = old & ~data;
			gpc_pkg::OP_TOGGLE: res = old ^ data;
		endcase
		return res;
	endfunction : apply_op

	// One write strobe per register; select code 7 matches none
	for (genvar r = 0; r < gpc_pkg::NUM_REGS; r++)
	begin : g_hit
		assign wr_hit[r] = reg_wr && reg_sel == 3'(r);
	end

	always_comb
	begin
		for (int r = 0; r < gpc_pkg::NUM_REGS; r++)
		begin
			nxt_regs[r] = regs_ff[r];
			if (wr_hit[r])
			begin
				nxt_regs[r] = apply_op(regs_ff[r], reg_wdata, reg_op);
			end
			nxt_regs[r] = nxt_regs[r] & IMPL_MASK;
		end
	end

	// No halt or debug input: registers run whenever clk runs
	// Holds while clk is stopped and resumes on its return
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int r = 0; r < gpc_pkg::NUM_REGS; r++)
			begin
				regs_ff[r] <= rst_val(r);
			end
		end
		else
		begin
			for (int r = 0; r < gpc_pkg::NUM_REGS; r++)
			begin
				regs_ff[r] <= nxt_regs[r];
			end
		end
	end

	assign own = regs_ff[gpc_pkg::REG_OWNERSHIP];
	assign drive_en = regs_ff[gpc_pkg::REG_DRIVE_EN];
	assign out_level = regs_ff[gpc_pkg::REG_OUT_LEVEL];
	assign pullup_en = regs_ff[gpc_pkg::REG_PULLUP_EN];
	assign irq_en = regs_ff[gpc_pkg::REG_IRQ_EN];
	assign fsel_bit0 = regs_ff[gpc_pkg::REG_FSEL0];
	assign fsel_bit1 = regs_ff[gpc_pkg::REG_FSEL1];

	// Two-flop synchroniser on the asynchronous pin levels
	always_comb
	begin
		nxt_sync1 = port_pin_n_in;
		nxt_sync2 = sync1_ff;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_ff <= gpc_pkg::RST_PIN_LEVEL;
			sync2_ff <= gpc_pkg::RST_PIN_LEVEL;
		end
		else
		begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
		end
	end

	// Pin level bits update only where they can matter, to save power
	assign level_upd = (own | irq_en) & IMPL_MASK;

	always_comb
	begin
		nxt_pin_level = pin_level_ff;
		for (int p = 0; p < gpc_pkg::NUM_PINS; p++)
		begin
			if (level_upd[p])
			begin
				nxt_pin_level[p] = sync2_ff[p];
			end
		end
		nxt_pin_level = nxt_pin_level & IMPL_MASK;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pin_level_ff <= gpc_pkg::RST_PIN_LEVEL;
		end
		else
		begin
			pin_level_ff <= nxt_pin_level;
		end
	end

	// Read-back multiplexer, registered
	always_comb
	begin
		nxt_rdata = 32'h00000000;
		unique case (reg_rsel)
			gpc_pkg::REG_OWNERSHIP: nxt_rdata = own;
			gpc_pkg::REG_DRIVE_EN: nxt_rdata = drive_en;
			gpc_pkg::REG_OUT_LEVEL: nxt_rdata = out_level;
			gpc_pkg::REG_PULLUP_EN: nxt_rdata = pullup_en;
			gpc_pkg::REG_IRQ_EN: nxt_rdata = irq_en;
			gpc_pkg::REG_FSEL0: nxt_rdata = fsel_bit0;
			gpc_pkg::REG_FSEL1: nxt_rdata = fsel_bit1;
			gpc_pkg::REG_PIN_LEVEL: nxt_rdata = pin_level_ff;
		endcase
		nxt_rdata = nxt_rdata & IMPL_MASK;
	end

	// Clock runs from reset; no logic here gates or stops it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_ff <= 32'h00000000;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	assign pin_level_reg = pin_level_ff;
	assign pin_irq_enable_reg = irq_en;

	// Per-pin path is combinational so it keeps working with clk stopped
	for (genvar p = 0; p < gpc_pkg::NUM_PINS; p++)
	begin : g_pin
		localparam int base_idx = p * gpc_pkg::NUM_FUNCS;
		logic [gpc_pkg::SEL_BITS-1:0] fsel;
		logic sel_out;
		logic sel_oe;
		logic sel_pull_en;
		logic sel_pull_ctl;
		logic pull_by_periph;
		assign fsel = {fsel_bit1[p], fsel_bit0[p]};
		assign sel_out = periph_out[base_idx + 32'(fsel)];
		assign sel_oe = periph_oe[base_idx + 32'(fsel)];
		assign sel_pull_en = periph_pull_en[base_idx + 32'(fsel)];
		assign sel_pull_ctl = periph_pull_ctl[base_idx + 32'(fsel)];
		assign pull_by_periph = !own[p] && PERIPH_PULL_MASK[p] && sel_pull_ctl;

		always_comb
		begin
			if (!IMPL_MASK[p])
			begin
				port_pin_n_out[p] = 1'b0;
				port_pin_n_oe[p] = 1'b0;
			end
			else if (own[p])
			begin
				port_pin_n_oe[p] = drive_en[p];
				port_pin_n_out[p] = out_level[p];
			end
			else
			begin
				// Clock-free selected function path
				port_pin_n_oe[p] = sel_oe;
				port_pin_n_out[p] = sel_out;
			end
		end

		always_comb
		begin
			if (!IMPL_MASK[p])
			begin
				port_pin_n_pullup[p] = 1'b0;
			end
			else if (pull_by_periph)
			begin
				port_pin_n_pullup[p] = sel_pull_en;
			end
			else
			begin
				port_pin_n_pullup[p] = pullup_en[p];
			end
		end

		for (genvar f = 0; f < gpc_pkg::NUM_FUNCS; f++)
		begin : g_fn
			// Pin input reaches only the selected function
			assign periph_in[base_idx + f] = !own[p]
				&& fsel == 2'(f) && port_pin_n_in[p];
		end
	end
endmodule : gpc_port

// [tb/gpc_port_monitor.sv]
// Purpose: Port-level checks of the pin control block
// Assumes: pull-up writes happen only while the port owns every pin
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
module gpc_port_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [2:0] reg_sel,
	input wire logic [1:0] reg_op,
	input wire logic [31:0] reg_wdata,
	input wire logic [2:0] reg_rsel,
	input wire logic [31:0] reg_rdata,
	input wire logic [31:0] pin_level_reg,
	input wire logic [31:0] pin_irq_enable_reg,
	input wire logic [31:0] port_pin_n_pullup
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic w_irq;
	assign w_irq = reg_wr && reg_sel == gpc_pkg::REG_IRQ_EN;
	set_ones_a: assert property (w_irq && reg_op == 2'h1 |=>
		pin_irq_enable_reg == ($past(pin_irq_enable_reg) | $past(reg_wdata)))
		else $error("set write wrong");
	clear_ones_a: assert property (w_irq && reg_op == 2'h2 |=>
		pin_irq_enable_reg == ($past(pin_irq_enable_reg) & ~$past(reg_wdata)))
		else $error("clear write wrong");
	toggle_ones_a: assert property (w_irq && reg_op == 2'h3 |=>
		pin_irq_enable_reg == ($past(pin_irq_enable_reg) ^ $past(reg_wdata)))
		else $error("toggle write wrong");
	plain_write_a: assert property (w_irq && reg_op == 2'h0 |=>
		pin_irq_enable_reg == $past(reg_wdata)) else $error("write wrong");
	read_irq_a: assert property (reg_rsel == 3'h4 |=>
		reg_rdata == $past(pin_irq_enable_reg)) else $error("read wrong");
	read_level_a: assert property (reg_rsel == 3'h7 |=>
		reg_rdata == $past(pin_level_reg)) else $error("level read wrong");
	bad_sel_a: assert property (reg_wr && reg_sel == 3'h7 |=>
		$stable(pin_irq_enable_reg)) else $error("sel 7 write took");
	pullup_set_a: assert property (reg_wr && reg_sel == 3'h3 && !reg_op |=>
		port_pin_n_pullup == $past(reg_wdata))
		else $error("pull-up wrong");
endmodule : gpc_port_chk
bind gpc_port gpc_port_chk u_chk (.*);

// [tb/gpc_pins.sv]
// Purpose: Pads and outside world of the port
// Assumes: bench keeps external drive off driven pins
// Notes: Floating unpulled pins flip every cycle
`timescale 1ns/1ps
module gpc_pins (
	input wire logic clk,
	input wire logic [31:0] out,
	input wire logic [31:0] oe,
	input wire logic [31:0] pu,
	input wire logic [31:0] ext_en,
	input wire logic [31:0] ext_val,
	output logic [31:0] lvl
);
	logic [31:0] flt_ff = 32'h0;
	always @(posedge clk) flt_ff <= ~flt_ff;
	assign lvl = (oe & out) | (~oe & ext_en & ext_val) |
		(~oe & ~ext_en & (pu | flt_ff));
endmodule : gpc_pins

// [tb/gpc_port_tb.sv]
// Purpose: Self-checking bench of the pin control block
// Assumes: default parameters, except PERIPH_PULL_MASK set to 32'h0000FFFF
// Notes: run gates the block clock to model sleep
`timescale 1ns/1ps
module gpc_port_tb;
	logic clk = 1'b0;
	logic run, rst, reg_wr;
	logic [2:0] reg_sel, reg_rsel;
	logic [1:0] reg_op;
	logic [31:0] reg_wdata, reg_rdata, lvl, p_in, p_out, p_oe, p_pu;
	logic [31:0] ext_en, ext_val;
	logic [127:0] pf_out, pf_oe, pf_pen, pf_pctl, pf_in;
	int bad_count = 0;
	int tests_run = 0;
	// Irq lines and their controller lie outside this block
	gpc_port #(.PERIPH_PULL_MASK(32'h0000FFFF)) u_dut (.clk(clk & run),
		.rst(rst), .reg_wr(reg_wr),
		.reg_sel(reg_sel), .reg_op(reg_op), .reg_wdata(reg_wdata),
		.reg_rsel(reg_rsel), .reg_rdata(reg_rdata), .pin_level_reg(lvl),
		.pin_irq_enable_reg(), .port_pin_n_in(p_in), .port_pin_n_out(p_out),
		.port_pin_n_oe(p_oe), .port_pin_n_pullup(p_pu), .periph_out(pf_out),
		.periph_oe(pf_oe), .periph_pull_en(pf_pen),
		.periph_pull_ctl(pf_pctl), .periph_in(pf_in));
	gpc_pins u_pins (.clk(clk), .out(p_out), .oe(p_oe), .pu(p_pu),
		.ext_en(ext_en), .ext_val(ext_val), .lvl(p_in));
	initial forever #25 clk = ~clk;
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [2:0] s, input logic [1:0] o,
		input logic [31:0] d);
		@(negedge clk);
		{reg_wr, reg_sel, reg_op, reg_wdata} = {1'b1, s, o, d};
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] s, input logic [31:0] e,
		input string nm);
		reg_rsel = s;
		@(negedge clk);
		chk(nm, e, reg_rdata);
	endtask : rd
	task automatic t_ops(input logic [2:0] r);
		logic [31:0] m, d;
		for (int i = 0; i < 4; i++)
		begin
			d = 32'hC3A5F00F << i;
			wr(r, 2'(i), d);
			m = i == 0 ? d : i == 1 ? m | d : i == 2 ? m & ~d : m ^ d;
			rd(r, m, "ops");
			if (r == gpc_pkg::REG_OUT_LEVEL)
				chk("out", m, p_out);
		end
	endtask : t_ops
	task automatic t_level;
		wr(3'h1, 2'h0, 32'h0);
		wr(3'h4, 2'h0, 32'h0);
		wr(3'h7, 2'h0, 32'hFFFFFFFF);
		rd(3'h4, 32'h0, "irq");
		{ext_en, ext_val} = {32'hFFFFFFFF, 32'h1234ABCD};
		repeat (4) @(negedge clk);
		rd(3'h7, 32'h1234ABCD, "lvl");
		wr(3'h0, 2'h0, 32'h0000FFFF);
		wr(3'h4, 2'h0, 32'h00FF0000);
		ext_val = 32'hEDCB5432;
		repeat (4) @(negedge clk);
		rd(3'h7, 32'h12CB5432, "gated");
	endtask : t_level
	task automatic t_periph;
		logic [31:0] a = 32'h00FF00FF;
		logic [31:0] b = 32'h0F0F0F0F;
		logic [31:0] e;
		logic [127:0] s, x;
		for (int p = 0; p < 32; p++)
			s[p*4 +: 4] = 4'h1 << {b[p], a[p]};
		wr(3'h0, 2'h0, 32'h0);
		wr(3'h5, 2'h0, a);
		wr(3'h6, 2'h0, b);
		// Clock stopped only once configuration is done
		{ext_en, pf_oe, run} = {32'h0, {128{1'b1}}, 1'b0};
		for (int f = 0; f < 4; f++)
		begin
			pf_out = {32{4'h1 << f}};
			x = pf_out & s;
			for (int p = 0; p < 32; p++)
				e[p] = {b[p], a[p]} == 2'(f);
			@(negedge clk);
			chk("pout", e, p_out);
			for (int q = 0; q < 4; q++)
				chk("pin_fn", x[q*32 +: 32], pf_in[q*32 +: 32]);
		end
		chk("poe", 32'hFFFFFFFF, p_oe);
		chk("frozen_lvl", 32'h12CB5432, lvl);
		{pf_pctl, pf_pen} = {{128{1'b1}}, {128{1'b1}}};
		@(negedge clk);
		chk("ppu", 32'hA5A5FFFF, p_pu);
		pf_pctl = '0;
		run = 1'b1;
		rd(3'h6, b, "frozen");
		wr(3'h0, 2'h0, 32'h0000000F);
		chk("own", 32'hFFFFFFF0, p_oe);
	endtask : t_periph
	initial
	begin
		{run, rst, reg_wr, reg_sel, reg_op, reg_wdata, reg_rsel} = {2'h3, 41'h0};
		{ext_en, ext_val, pf_out, pf_oe, pf_pen, pf_pctl} = '0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		rd(3'h0, gpc_pkg::RST_OWNERSHIP, "own");
		rd(3'h1, 32'h0, "drv");
		chk("oe0", 32'h0, p_oe);
		wr(3'h1, 2'h0, 32'hFFFFFFFF);
		wr(3'h3, 2'h0, 32'hA5A55A5A);
		chk("pu", 32'hA5A55A5A, p_pu);
		t_ops(gpc_pkg::REG_IRQ_EN);
		t_ops(gpc_pkg::REG_OUT_LEVEL);
		t_level;
		t_periph;
		print_verdict;
	end
	initial
	begin
		#2000000;
		bad_count++;
		print_verdict;
	end
endmodule : gpc_port_tb
